// ### dv/ida_core_tb.sv
// Self-checking bench of the slave data and own-address block.
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
module ida_core_tb;
	import ida_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, cyc, stb, we, ack, irq, s, scl_oe, sda_oe;
	logic m_scl_low, m_sda_low, scl, sda;
	logic [7:0] adr, a8, lo, rb;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rnd, exp_v;
	logic [1:0] hi, bd;
	logic [31:0] exp_q[$];
	int error_cnt = 0;
	int num_checks = 0;
	assign scl = !(m_scl_low || scl_oe);
	assign sda = !(m_sda_low || sda_oe);
	ida_core dut (.i_mclk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_scl(scl),
		.o_scl(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(),
		.o_sda_oe(sda_oe), .o_irq(irq));
	ida_i2c_host_model m (.i_mclk(clk), .i_scl(scl), .i_sda(sda),
		.o_scl_low(m_scl_low), .o_sda_low(m_sda_low));
	initial begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic wb(input logic w, input logic [5:0] ix, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'b00};
		wdat <= {PAD_ZERO, d};
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 100);
		if (k >= 100) error_cnt++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] ix, input logic [7:0] e);
		exp_q.push_back({PAD_ZERO, e});
		wb(1'b0, ix, 8'h00);
	endtask
	// Read results are compared in order as the slave answers them.
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
			exp_v = exp_q.pop_front();
			`CHK("rdata", exp_v, rdat)
		end
	end
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#800us;
		error_cnt++;
		final_report();
	end
	initial begin
		{cyc, stb, we, adr, wdat} = '0;
		sel = 4'hF;
		rst_b = 1'b0;
		rnd = lfsr(32'hBE2FFEA7);
		a8 = {2'b01, rnd[4:0], 1'b0};
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rd(IDX_CTRL, 8'h00);
		rd(IDX_OWN_SLAVE_ID_LOW, 8'h00);
		rd(IDX_OWN_SLAVE_ID_HIGH_AND_BAND, OWN_SLAVE_ID_HIGH_AND_BAND_RST);
		rd(IDX_DR, 8'h00);
		rd(6'h3F, 8'h00);
		wb(1'b1, IDX_OWN_SLAVE_ID_HIGH_AND_BAND, 8'hFF);
		rd(IDX_OWN_SLAVE_ID_HIGH_AND_BAND, OWN_SLAVE_ID_HIGH_AND_BAND_RMASK);
		wb(1'b1, IDX_OWN_SLAVE_ID_HIGH_AND_BAND, 8'h00);
		wb(1'b1, IDX_OWN_SLAVE_ID_LOW, a8 | 8'h01);
		wb(1'b1, IDX_IRQ_MASK, 8'h1F);
		wb(1'b1, IDX_CTRL, 8'h24);
		wb(1'b1, IDX_OWN_SLAVE_ID_HIGH_AND_BAND, 8'hC0);
		rd(IDX_OWN_SLAVE_ID_HIGH_AND_BAND, 8'h00);
		rnd = lfsr(rnd);
		m.start();
		m.put_byte(a8, s);
		`CHK("addr ack", 1'b0, s)
		m.put_byte(rnd[7:0], s);
		`CHK("irq", 1'b1, irq)
		fork
			m.put_byte(rnd[15:8], s);
			begin
				repeat (200) @(posedge clk);
				`CHK("stretch", 1'b1, scl_oe)
				rd(IDX_DR, rnd[7:0]);
			end
		join
		`CHK("data ack", 1'b0, s)
		rd(IDX_DR, rnd[15:8]);
		wb(1'b1, IDX_IRQ_ST, 8'h1F);
		@(posedge clk);
		`CHK("irq clr", 1'b0, irq)
		m.stop();
		m.start();
		m.put_byte(a8 | 8'h01, s);
		`CHK("rd ack", 1'b0, s)
		fork
			m.get_byte(rb, 1'b1);
			begin
				repeat (100) @(posedge clk);
				wb(1'b1, IDX_DR, rnd[23:16]);
			end
		join
		`CHK("tx byte", rnd[23:16], rb)
		m.stop();
		wb(1'b1, IDX_CTRL, 8'h00);
		wb(1'b1, IDX_OWN_SLAVE_ID_LOW, 8'h02);
		wb(1'b1, IDX_CTRL, 8'h24);
		m.start();
		m.put_byte(8'h02, s);
		`CHK("addr 01", 1'b1, s)
		m.stop();
		for (int t = 0; t < 2; t++) begin
			rnd = lfsr(rnd);
			hi = rnd[1:0];
			lo = rnd[15:8];
			bd = {~t[0], rnd[2]};
			wb(1'b1, IDX_CTRL, 8'h00);
			wb(1'b1, IDX_OWN_SLAVE_ID_HIGH_AND_BAND, {bd, 3'h0, hi, 1'b0});
			wb(1'b1, IDX_OWN_SLAVE_ID_LOW, lo);
			wb(1'b1, IDX_CTRL, 8'hA4);
			m.start();
			m.put_byte({TEN_HDR, hi, 1'b0}, s);
			`CHK("hdr ack", 1'b0, s)
			m.put_byte(lo ^ {7'h00, t[0]}, s);
			`CHK("low ack", t[0], s)
			if (t == 0) begin
				m.put_byte(rnd[23:16], s);
				rd(IDX_DR, rnd[23:16]);
			end
			m.stop();
			wb(1'b1, IDX_CTRL, 8'h00);
			rd(IDX_OWN_SLAVE_ID_LOW, lo);
			rd(IDX_OWN_SLAVE_ID_HIGH_AND_BAND, {bd, 3'h0, hi, 1'b0});
		end
		wb(1'b1, IDX_CTRL, 8'hA4);
		m.start();
		m.put_byte({TEN_HDR, ~hi, 1'b0}, s);
		`CHK("hdr miss", 1'b1, s)
		m.stop();
		final_report();
	end
endmodule

// ### dv/ida_i2c_host_model.sv
// Behavioural bus master that talks to the slave over open-drain lines.
module ida_i2c_host_model (
	input wire logic i_mclk,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_low,
	output logic o_sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// The slave may stretch the low phase, so the wait is for the wire.
	task automatic wait_high();
		int k;
		k = 0;
		do begin
			tick(1);
			k++;
		end while (i_scl !== 1'b1 && k < 3000);
	endtask
	// Low phase of six cycles, high of two: 80 ns per bit.
	task automatic clk_bit(input logic b, output logic s);
		tick(2);
		o_sda_low <= !b;
		tick(4);
		o_scl_low <= 1'b0;
		wait_high();
		tick(1);
		s = i_sda;
		o_scl_low <= 1'b1;
	endtask
	task automatic start();
		if (o_scl_low) begin
			tick(2);
			o_sda_low <= 1'b0;
			tick(4);
			o_scl_low <= 1'b0;
			wait_high();
			tick(3);
		end
		o_sda_low <= 1'b1;
		tick(4);
		o_scl_low <= 1'b1;
	endtask
	task automatic stop();
		tick(2);
		o_sda_low <= 1'b1;
		tick(4);
		o_scl_low <= 1'b0;
		tick(3);
		o_sda_low <= 1'b0;
		tick(8);
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack_lvl);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
		clk_bit(1'b1, ack_lvl);
	endtask
	task automatic get_byte(output logic [7:0] b, input logic ack_lvl);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
		clk_bit(ack_lvl, s);
	endtask
endmodule

// ### rtl/ida_core.sv
// Register file, Wishbone slave and byte engine of the I2C slave interface.
// Functional notes
// - Eight-bit data byte register holds bus byte.
// - Writing data byte starts transmission automatically.
// - Received address LSB selects direction; capture byte.
// - Next received byte waits for data read.
// - Seven-bit address from own id bits 7:1.
// - Direction bit zero ignored when matching.
// - Received seven-bit address 01h never matches.
// - Ten-bit mode uses all eight low bits.
// - Ten-bit bits 9:8 from high register 2:1.
// - Speed band selects bus hold delays.
//
// Added by the designer: register access over Wishbone.
module ida_core (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [ida_pkg::WB_AW-1:0] i_wb_adr,
	input wire logic [ida_pkg::WB_SW-1:0] i_wb_sel,
	input wire logic [ida_pkg::WB_DW-1:0] i_wb_dat,
	output logic [ida_pkg::WB_DW-1:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_scl,
	output logic o_scl,
	output logic o_scl_oe,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	output logic o_irq
);
	import ida_pkg::*;

	logic ack_q;
	logic [WB_DW-1:0] rdat_q;
	logic [7:0] ctrl_q, ccr_q, own_slave_id_low_q, own_slave_id_high_and_band_q, dr_q, sr2_q;
	logic [7:0] sr1, sr2_set, rd_byte;
	logic [IRQ_W-1:0] irq_st_q, irq_mask_q, ev;
	ida_state_t state_q, state_d;
	logic [7:0] shift_q, shift_d;
	logic [3:0] bit_q, bit_d;
	logic dir_tx_q, dir_d, ten_hit_q, ten_d;
	logic rx_full_q, tx_full_q, rx_load, tx_take, want_tx;
	logic sda_tgt_q, tgt_d, sda_oe_q, scl_oe_q;
	logic [2:0] hold_q;
	logic scl_rise, scl_fall, sda_lvl, start_det, stop_det;

	ida_pin_sync u_sync (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_scl_rise(scl_rise),
		.o_scl_fall(scl_fall),
		.o_sda_lvl(sda_lvl),
		.o_start(start_det),
		.o_stop(stop_det)
	);

	wire logic [IDX_W-1:0] idx = i_wb_adr[WB_AW-1:2];
	wire logic req = i_wb_cyc & i_wb_stb;
	wire logic wr_fire = req & i_wb_we & ack_q & i_wb_sel[0];
	wire logic rd_fire = req & ~i_wb_we & ack_q;
	wire logic [7:0] wb_byte = i_wb_dat[7:0];
	wire logic wr_ctrl = wr_fire & (idx == IDX_CTRL);
	wire logic wr_ccr = wr_fire & (idx == IDX_CCR);
	wire logic wr_own_slave_id_low = wr_fire & (idx == IDX_OWN_SLAVE_ID_LOW);
	wire logic wr_own_slave_id_high_and_band = wr_fire & (idx == IDX_OWN_SLAVE_ID_HIGH_AND_BAND);
	wire logic wr_dr = wr_fire & (idx == IDX_DR);
	wire logic wr_ist = wr_fire & (idx == IDX_IRQ_ST);
	wire logic wr_imask = wr_fire & (idx == IDX_IRQ_MASK);
	wire logic rd_sr2 = rd_fire & (idx == IDX_SR2);
	wire logic rd_dr = rd_fire & (idx == IDX_DR);
	wire logic pe = ctrl_q[CTRL_PE];
	wire logic ack_en = ctrl_q[CTRL_ACK];
	wire logic ten_mode = ctrl_q[CTRL_TEN];
	wire logic [1:0] band = own_slave_id_high_and_band_q[7:6];
	wire logic fall8 = scl_fall & (bit_q == BITS_PER_BYTE);
	wire logic busy = state_q != ST_IDLE;
	wire logic addressed = busy & (state_q != ST_ADDR) &
		(state_q != ST_HACK) & (state_q != ST_ADDR2);
	// A direction bit of either value matches; 01h is a reserved address.
	wire logic hit7 = ~ten_mode & ack_en &
		(shift_q[7:1] == own_slave_id_low_q[7:1]) &
		(shift_q[7:1] != RSVD_ADDR7);
	wire logic hit10 = ten_mode & ack_en & (shift_q[7:3] == TEN_HDR) &
		(shift_q[2:1] == own_slave_id_high_and_band_q[2:1]);

	assign rd_byte = (idx == IDX_CTRL) ? ctrl_q :
		(idx == IDX_SR1) ? sr1 :
		(idx == IDX_SR2) ? sr2_q :
		(idx == IDX_CCR) ? ccr_q :
		(idx == IDX_OWN_SLAVE_ID_LOW) ? own_slave_id_low_q :
		(idx == IDX_OWN_SLAVE_ID_HIGH_AND_BAND) ? (own_slave_id_high_and_band_q & OWN_SLAVE_ID_HIGH_AND_BAND_RMASK) :
		(idx == IDX_DR) ? dr_q :
		(idx == IDX_IRQ_ST) ? {3'h0, irq_st_q} :
		(idx == IDX_IRQ_MASK) ? {3'h0, irq_mask_q} : BYTE_ZERO;

	always_comb begin
		sr1 = BYTE_ZERO;
		sr1[SR1_EVF] = |irq_st_q;
		sr1[SR1_TRA] = dir_tx_q & addressed;
		sr1[SR1_BUSY] = busy;
		sr1[SR1_BTF] = (state_q == ST_TWAIT) | (state_q == ST_RHOLD);
		sr1[SR1_ADSL] = addressed;
		sr2_set = BYTE_ZERO;
		sr2_set[SR2_AF] = ev[IRQ_AF];
		sr2_set[SR2_STOPF] = ev[IRQ_STOP];
	end

	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		bit_d = bit_q;
		dir_d = dir_tx_q;
		ten_d = ten_hit_q;
		tgt_d = sda_tgt_q;
		rx_load = 1'h0;
		tx_take = 1'h0;
		want_tx = 1'h0;
		ev = '0;
		if (!pe) begin
			state_d = ST_IDLE;
			tgt_d = 1'h0;
			ten_d = 1'h0;
		end else if (stop_det) begin
			ev[IRQ_STOP] = addressed;
			state_d = ST_IDLE;
			tgt_d = 1'h0;
			ten_d = 1'h0;
		end else if (start_det) begin
			state_d = ST_ADDR;
			bit_d = 4'h0;
			tgt_d = 1'h0;
		end else begin
			case (state_q)
			ST_ADDR, ST_ADDR2, ST_RX: begin
				if (scl_rise) begin
					shift_d = {shift_q[BYTE_MSB-1:0], sda_lvl};
					bit_d = bit_q + 4'h1;
				end else if (fall8) begin
					bit_d = 4'h0;
					state_d = ST_IDLE;
					if (state_q == ST_RX) begin
						// The byte is held back until software has read the last.
						if (rx_full_q) begin
							state_d = ST_RHOLD;
						end else begin
							rx_load = 1'h1;
							tgt_d = ack_en;
							state_d = ST_RACK;
							ev[IRQ_RX] = 1'h1;
						end
					end else if (state_q == ST_ADDR2) begin
						if (shift_q == own_slave_id_low_q) begin
							tgt_d = 1'h1;
							dir_d = 1'h0;
							state_d = ST_AACK;
							ev[IRQ_ADDR] = 1'h1;
						end else begin
							ten_d = 1'h0;
						end
					end else if (hit7) begin
						tgt_d = 1'h1;
						dir_d = shift_q[0];
						state_d = ST_AACK;
						ev[IRQ_ADDR] = 1'h1;
					end else if (hit10 & ~shift_q[0]) begin
						tgt_d = 1'h1;
						ten_d = 1'h1;
						state_d = ST_HACK;
					end else if (hit10 & ten_hit_q) begin
						tgt_d = 1'h1;
						dir_d = 1'h1;
						state_d = ST_AACK;
						ev[IRQ_ADDR] = 1'h1;
					end
				end
			end
			ST_HACK: begin
				if (scl_fall) begin
					tgt_d = 1'h0;
					bit_d = 4'h0;
					state_d = ST_ADDR2;
				end
			end
			ST_AACK: begin
				if (scl_fall) begin
					tgt_d = 1'h0;
					bit_d = 4'h0;
					want_tx = dir_tx_q;
					state_d = ST_RX;
				end
			end
			ST_RHOLD: begin
				if (!rx_full_q) begin
					rx_load = 1'h1;
					tgt_d = ack_en;
					state_d = ST_RACK;
					ev[IRQ_RX] = 1'h1;
				end
			end
			ST_RACK: begin
				if (scl_fall) begin
					tgt_d = 1'h0;
					bit_d = 4'h0;
					state_d = ST_RX;
				end
			end
			ST_TWAIT: want_tx = tx_full_q;
			ST_TX: begin
				if (scl_fall) begin
					if (bit_q == TX_LAST_BIT) begin
						tgt_d = 1'h0;
						bit_d = 4'h0;
						state_d = ST_TACK;
					end else begin
						shift_d = {shift_q[BYTE_MSB-1:0], 1'h0};
						tgt_d = ~shift_q[BYTE_MSB-1];
						bit_d = bit_q + 4'h1;
					end
				end
			end
			ST_TACK: begin
				if (scl_rise & sda_lvl) begin
					ev[IRQ_AF] = 1'h1;
					state_d = ST_IDLE;
				end else if (scl_fall) begin
					want_tx = 1'h1;
				end
			end
			ST_IDLE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
			endcase
			if (want_tx) begin
				if (tx_full_q) begin
					shift_d = dr_q;
					tgt_d = ~dr_q[BYTE_MSB];
					bit_d = 4'h0;
					tx_take = 1'h1;
					state_d = ST_TX;
				end else begin
					ev[IRQ_TX] = state_q != ST_TWAIT;
					state_d = ST_TWAIT;
				end
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ack_q <= 1'h0;
			rdat_q <= '0;
		end else begin
			ack_q <= req & ~ack_q;
			if (req & ~ack_q)
				rdat_q <= {PAD_ZERO, rd_byte};
		end
	end

	// Own address and clock settings survive the interface being switched off.
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_q <= BYTE_ZERO;
			ccr_q <= BYTE_ZERO;
			own_slave_id_low_q <= BYTE_ZERO;
			own_slave_id_high_and_band_q <= OWN_SLAVE_ID_HIGH_AND_BAND_RST;
			irq_mask_q <= '0;
		end else begin
			if (wr_ctrl)
				ctrl_q <= wb_byte & CTRL_WMASK;
			if (wr_ccr)
				ccr_q <= wb_byte;
			if (wr_own_slave_id_low)
				own_slave_id_low_q <= wb_byte;
			// A band change while running would upset a live transfer.
			if (wr_own_slave_id_high_and_band)
				own_slave_id_high_and_band_q <= ((pe ? own_slave_id_high_and_band_q : wb_byte) & BAND_MASK) |
					(wb_byte & ADDR_HI_MASK);
			if (wr_imask)
				irq_mask_q <= wb_byte[IRQ_W-1:0];
		end
	end

	// Hardware sets win over software clears in the same cycle.
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sr2_q <= BYTE_ZERO;
			irq_st_q <= '0;
			rx_full_q <= 1'h0;
			tx_full_q <= 1'h0;
			dr_q <= BYTE_ZERO;
		end else begin
			sr2_q <= pe ? ((rd_sr2 ? BYTE_ZERO : sr2_q) | sr2_set) : BYTE_ZERO;
			irq_st_q <= (irq_st_q & ~(wr_ist ? wb_byte[IRQ_W-1:0] : '0)) | ev;
			rx_full_q <= pe & (rx_load | (rx_full_q & ~rd_dr));
			tx_full_q <= wr_dr | (pe & tx_full_q & ~tx_take);
			if (rx_load)
				dr_q <= shift_q;
			else if (wr_dr)
				dr_q <= wb_byte;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q <= ST_IDLE;
			shift_q <= BYTE_ZERO;
			bit_q <= 4'h0;
			dir_tx_q <= 1'h0;
			ten_hit_q <= 1'h0;
			sda_tgt_q <= 1'h0;
			scl_oe_q <= 1'h0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			bit_q <= bit_d;
			dir_tx_q <= dir_d;
			ten_hit_q <= ten_d;
			sda_tgt_q <= tgt_d;
			// Stretch SCL until SDA has settled, so no bit changes while high.
			scl_oe_q <= pe & ((state_d == ST_TWAIT) | (state_d == ST_RHOLD) |
				(tgt_d != sda_tgt_q) | (hold_q != HOLD_ZERO));
		end
	end

	// SDA follows its target only after the band's hold time past SCL fall.
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hold_q <= HOLD_ZERO;
			sda_oe_q <= 1'h0;
		end else if (!pe) begin
			hold_q <= HOLD_ZERO;
			sda_oe_q <= 1'h0;
		end else if (tgt_d != sda_tgt_q) begin
			hold_q <= band_hold(band);
		end else if (hold_q != HOLD_ZERO) begin
			hold_q <= hold_q - HOLD_ONE;
			if (hold_q == HOLD_ONE)
				sda_oe_q <= sda_tgt_q;
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;
	assign o_scl = 1'h0;
	assign o_sda = 1'h0;
	assign o_scl_oe = scl_oe_q;
	assign o_sda_oe = sda_oe_q;
	assign o_irq = |(irq_st_q & irq_mask_q);

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_b);

	wire logic quiet = pe & ~start_det & ~stop_det;
	wire logic addr_done = quiet & (state_q == ST_ADDR) & fall8;

	sequence s_tx_armed;
		quiet & (state_q == ST_TWAIT) & tx_full_q;
	endsequence
	sequence s_tgt_settled;
		(pe & $changed(sda_tgt_q)) ##1 (pe & $stable(sda_tgt_q))[*4];
	endsequence

	a_wb_ack_once: assert property (ack_q |=> !ack_q)
		else $error("bus ack lasted more than one cycle");
	a_dr_read_frees: assert property (
		rd_dr & ~rx_load |=> !rx_full_q)
		else $error("data read did not free the receive slot");
	a_rx_holds_off: assert property (
		quiet & (state_q == ST_RHOLD) & rx_full_q & ~rd_dr
		|=> state_q == ST_RHOLD)
		else $error("byte accepted before previous one was read");
	a_rx_capture: assert property (
		rx_load |=> rx_full_q && dr_q == $past(shift_q))
		else $error("received byte not captured in data register");
	a_tx_auto_go: assert property (
		s_tx_armed |=> state_q == ST_TX && !tx_full_q)
		else $error("written byte did not start transmission");
	a_hit_seven: assert property (
		addr_done & hit7
		|=> state_q == ST_AACK && dir_tx_q == $past(shift_q[0]))
		else $error("own seven-bit address not acknowledged");
	a_skip_addr_one: assert property (
		addr_done & ~ten_mode & (shift_q[7:1] == RSVD_ADDR7)
		|=> state_q == ST_IDLE)
		else $error("address 01h was treated as a match");
	a_ten_high_miss: assert property (
		addr_done & ten_mode & (shift_q[2:1] != own_slave_id_high_and_band_q[2:1])
		|=> state_q == ST_IDLE)
		else $error("ten-bit header with wrong high bits matched");
	a_ten_low_miss: assert property (
		quiet & (state_q == ST_ADDR2) & fall8 & (shift_q != own_slave_id_low_q)
		|=> state_q == ST_IDLE)
		else $error("ten-bit low byte mismatch was acknowledged");
	a_resv_zero: assert property (
		ack_q & (idx == IDX_OWN_SLAVE_ID_HIGH_AND_BAND) & ~i_wb_we
		|-> (o_wb_dat[7:0] & ~OWN_SLAVE_ID_HIGH_AND_BAND_RMASK) == BYTE_ZERO)
		else $error("reserved own-address bits read non-zero");
	a_band_delay: assert property (
		s_tgt_settled |-> ##1 (sda_oe_q == sda_tgt_q))
		else $error("SDA did not follow target within hold time");
endmodule

// ### rtl/ida_pin_sync.sv
// Bus pin synchronisers with edge, start and stop detection.
module ida_pin_sync (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_rise,
	output logic o_scl_fall,
	output logic o_sda_lvl,
	output logic o_start,
	output logic o_stop
);
	logic scl_m_q, scl_s_q, scl_d_q;
	logic sda_m_q, sda_s_q, sda_d_q;

	// Reset to the idle bus level so no false start is seen on release.
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scl_m_q <= 1'h1;
			scl_s_q <= 1'h1;
			scl_d_q <= 1'h1;
			sda_m_q <= 1'h1;
			sda_s_q <= 1'h1;
			sda_d_q <= 1'h1;
		end else begin
			scl_m_q <= i_scl;
			scl_s_q <= scl_m_q;
			scl_d_q <= scl_s_q;
			sda_m_q <= i_sda;
			sda_s_q <= sda_m_q;
			sda_d_q <= sda_s_q;
		end
	end

	assign o_scl_rise = scl_s_q & ~scl_d_q;
	assign o_scl_fall = ~scl_s_q & scl_d_q;
	assign o_sda_lvl = sda_s_q;
	assign o_start = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
	assign o_stop = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;
endmodule

// ### rtl/ida_pkg.sv
// Constants, register map and types shared by the I2C data and address block.
package ida_pkg;
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;
	localparam int WB_SW = 4;
	localparam int IDX_W = WB_AW - 2;

	// Word indices; the byte address on the bus is four times the index.
	localparam logic [IDX_W-1:0] IDX_CTRL = 6'h18;
	localparam logic [IDX_W-1:0] IDX_SR1 = 6'h19;
	localparam logic [IDX_W-1:0] IDX_SR2 = 6'h1A;
	localparam logic [IDX_W-1:0] IDX_CCR = 6'h1B;
	localparam logic [IDX_W-1:0] IDX_OWN_SLAVE_ID_LOW = 6'h1C;
	localparam logic [IDX_W-1:0] IDX_OWN_SLAVE_ID_HIGH_AND_BAND = 6'h1D;
	localparam logic [IDX_W-1:0] IDX_DR = 6'h1E;
	localparam logic [IDX_W-1:0] IDX_IRQ_ST = 6'h20;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h21;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] OWN_SLAVE_ID_HIGH_AND_BAND_RST = 8'h40;
	localparam logic [7:0] OWN_SLAVE_ID_HIGH_AND_BAND_RMASK = 8'hC6;
	localparam logic [7:0] BAND_MASK = 8'hC0;
	localparam logic [7:0] ADDR_HI_MASK = 8'h06;
	localparam logic [7:0] CTRL_WMASK = 8'hBF;
	localparam logic [23:0] PAD_ZERO = 24'h000000;

	localparam int CTRL_TEN = 7;
	localparam int CTRL_PE = 5;
	localparam int CTRL_ACK = 2;
	localparam int SR1_EVF = 7;
	localparam int SR1_TRA = 5;
	localparam int SR1_BUSY = 4;
	localparam int SR1_BTF = 3;
	localparam int SR1_ADSL = 2;
	localparam int SR2_AF = 4;
	localparam int SR2_STOPF = 3;
	localparam int BYTE_MSB = 7;

	localparam int IRQ_W = 5;
	localparam int IRQ_ADDR = 0;
	localparam int IRQ_RX = 1;
	localparam int IRQ_TX = 2;
	localparam int IRQ_AF = 3;
	localparam int IRQ_STOP = 4;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] TX_LAST_BIT = 4'h7;
	localparam logic [4:0] TEN_HDR = 5'h1E;
	localparam logic [6:0] RSVD_ADDR7 = 7'h01;

	localparam logic [1:0] BAND_LOW = 2'h0;
	localparam logic [1:0] BAND_MID = 2'h1;
	localparam int CLK_MHZ = 100;
	localparam int HOLD_LOW_NS = 10;
	localparam int HOLD_MID_NS = 20;
	localparam int HOLD_HIGH_NS = 40;
	localparam logic [2:0] HOLD_LOW_CYC =
		3'((HOLD_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [2:0] HOLD_MID_CYC =
		3'((HOLD_MID_NS * CLK_MHZ + 999) / 1000);
	localparam logic [2:0] HOLD_HIGH_CYC =
		3'((HOLD_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [2:0] HOLD_ZERO = 3'h0;
	localparam logic [2:0] HOLD_ONE = 3'h1;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_HACK, ST_ADDR2, ST_AACK, ST_RX, ST_RHOLD,
		ST_RACK, ST_TWAIT, ST_TX, ST_TACK
	} ida_state_t;

	function automatic logic [2:0] band_hold(input logic [1:0] band);
		case (band)
			BAND_LOW: band_hold = HOLD_LOW_CYC;
			BAND_MID: band_hold = HOLD_MID_CYC;
			default: band_hold = HOLD_HIGH_CYC;
		endcase
	endfunction
endpackage
